//--- core/qfx_params.svh
`ifndef QFX_PARAMS_SVH
`define QFX_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses).
`define QFX_ADDR_CTRL       12'h000
`define QFX_ADDR_STATUS     12'h004
`define QFX_ADDR_LAST_QOS   12'h008
`define QFX_ADDR_FLAGS_LO   12'h00C
`define QFX_ADDR_FLAGS_HI   12'h010
`define QFX_PORT_BASE       12'h100
`define QFX_PORT_WORDS      4'hA
`define QFX_CTRL_RESET      32'h0000_0001
`define QFX_CTRL_DERIVE     0

// ==========================================================================
// Word slots inside one port block.
`define QFX_SLOT_OUTER      4'h0
`define QFX_SLOT_INNER      4'h2
`define QFX_SLOT_SPARE      4'h4
`define QFX_SLOT_INIT_LO    4'h6
`define QFX_SLOT_INIT_HI    4'h8

// ==========================================================================
// Header field word positions.
`define QFX_W_SWPRI         0
`define QFX_W_OUTER         1
`define QFX_W_INNER         2
`define QFX_W_SPARE         11
`define QFX_W_NET           16
`define QFX_W_INIT_HI_BASE  8
`define QFX_SWPRI_LSB       8
`define QFX_VPRI_LSB        12
`define QFX_SPARE_LSB       8
`define QFX_NET_LSB         0
`define QFX_NIB             4
`define QFX_BYTE            8
`define QFX_QOS_SWPRI_LSB   20
`define QFX_QOS_NET_LSB     4

// ==========================================================================
// Flag bit positions and constants.
`define QFX_F_TAG_PRESENT   1
`define QFX_F_TAG_FMT       2
`define QFX_F_DEST_NZ       10
`define QFX_F_SRC_NZ        11
`define QFX_F_MAPPED        12
`define QFX_F_HOP           13
`define QFX_F_MCAST         17
`define QFX_F_SUM           37
`define QFX_F_SHORT         38
`define QFX_F_PARITY        39
`define QFX_SUM_GOOD        16'hFFFF
`define QFX_MAPPED_PATTERN  96'h0000_0000_0000_0000_0000_FFFF
`define QFX_HOP_EXPIRED_MAX 8'h01
`define QFX_MAC_MCAST_BIT   40
`define QFX_DSCP_LSB        2
`define QFX_DSCP_W          6

// ==========================================================================
// AXI responses.
`define QFX_RESP_OKAY       2'b00
`define QFX_RESP_DECERR     2'b11

`endif

//--- core/qfx_pkg.sv
package qfx_pkg;

	// ======================================================================
	// Grouped QoS channel, most significant field first.
	typedef struct packed {
		logic [3:0] switch_tag_priority;
		logic [3:0] outer_vlan_priority;
		logic [3:0] inner_vlan_priority;
		logic [7:0] network_priority;
		logic [3:0] spare_qos_nibble;
	} qfx_qos_t;

	typedef logic [1:0] qfx_resp_t;

endpackage

//--- core/qfx_extract.sv
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "qfx_params.svh"

module qfx_extract
	import qfx_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// Clock, reset and enable.
	input  wire logic               CLK_IN,
	input  wire logic               RST_IN,
	input  wire logic               CE_IN,
	// Parser side.
	input  wire logic               FRAME_VALID_IN,
	input  wire logic [5:0]         SRC_PORT_IN,
	input  wire logic [43:0][15:0]  FIELDS_IN,
	input  wire logic [43:0]        FIELD_WRITTEN_IN,
	input  wire logic [39:0]        PARSER_FLAGS_IN,
	input  wire logic [15:0]        HEADER_SUM_IN,
	input  wire logic               SHORT_HEADER_IN,
	input  wire logic               PARITY_FAULT_IN,
	input  wire logic [15:0]        DEST_PORT_TAG_ID_IN,
	input  wire logic [15:0]        SRC_PORT_TAG_ID_IN,
	input  wire logic [127:0]       DEST_IP_IN,
	input  wire logic [7:0]         HOP_LIMIT_IN,
	input  wire logic [47:0]        DEST_MAC_IN,
	// Downstream side.
	output logic                    FRAME_VALID_OUT,
	output logic [23:0]             QOS_OUT,
	output logic [3:0]              SWITCH_TAG_PRIORITY_OUT,
	output logic [3:0]              OUTER_VLAN_PRIORITY_OUT,
	output logic [3:0]              INNER_VLAN_PRIORITY_OUT,
	output logic [7:0]              NETWORK_PRIORITY_OUT,
	output logic [5:0]              DSCP_OUT,
	output logic [3:0]              SPARE_QOS_NIBBLE_OUT,
	output logic [39:0]             ACTION_FLAGS_OUT,
	// AXI4-Lite slave.
	input  wire logic [11:0]        AWADDR_IN,
	input  wire logic               AWVALID_IN,
	output logic                    AWREADY_OUT,
	input  wire logic [31:0]        WDATA_IN,
	input  wire logic [3:0]         WSTRB_IN,
	input  wire logic               WVALID_IN,
	output logic                    WREADY_OUT,
	output logic [1:0]              BRESP_OUT,
	output logic                    BVALID_OUT,
	input  wire logic               BREADY_IN,
	input  wire logic [11:0]        ARADDR_IN,
	input  wire logic               ARVALID_IN,
	output logic                    ARREADY_OUT,
	output logic [31:0]             RDATA_OUT,
	output logic [1:0]              RRESP_OUT,
	output logic                    RVALID_OUT,
	input  wire logic               RREADY_IN
);

	// ======================================================================
	// State.
	typedef struct packed {
		logic [31:0]                                ctrl;
		logic [31:0]                                frame_count;
		logic [NUM_PORTS-1:0][9:0][31:0]            port_regs;
		logic                                       aw_got;
		logic                                       w_got;
		logic [11:0]                                awaddr;
		logic [31:0]                                wdata;
		logic [3:0]                                 wstrb;
		logic                                       bvalid;
		qfx_resp_t                                  bresp;
		logic                                       rvalid;
		qfx_resp_t                                  rresp;
		logic [31:0]                                rdata;
		logic                                       out_valid;
		qfx_qos_t                                   qos;
		logic [39:0]                                flags;
	} qfx_state_t;

	qfx_state_t st;
	qfx_state_t next_st;

	// ======================================================================
	// Helpers.

	// Picks one nibble from a 16-entry table held in two words.
	function automatic logic [3:0] qfx_lookup(input logic [31:0] lo, input logic [31:0] hi,
		input logic [3:0] idx);
		logic [63:0] tbl;
		tbl = {hi, lo};
		return tbl[{idx, 2'b00} +: `QFX_NIB];
	endfunction

	// Decodes a port block address; ok is low for unmapped slots.
	function automatic void qfx_decode(input logic [11:0] addr, output logic ok,
		output logic [5:0] port, output logic [3:0] slot);
		logic [11:0] off;
		off = addr - `QFX_PORT_BASE;
		port = off[11:6];
		slot = off[5:2];
		ok = (addr >= `QFX_PORT_BASE) && (port < 6'(NUM_PORTS)) && (slot < `QFX_PORT_WORDS);
	endfunction

	// ======================================================================
	// Frame path signals.
	logic [NUM_PORTS-1:0][9:0][31:0] pr;
	logic [9:0][31:0]                cur;
	logic [5:0]                      port_idx;
	logic [3:0][15:0]                eff;
	logic [15:0]                     w_net;
	qfx_qos_t                        next_qos;
	logic [39:0]                     next_flags;
	logic                            derive;

	assign pr = st.port_regs;
	assign port_idx = (SRC_PORT_IN < 6'(NUM_PORTS)) ? SRC_PORT_IN : 6'h00;
	assign cur = pr[port_idx[$clog2(NUM_PORTS > 1 ? NUM_PORTS : 2)-1:0]];
	assign derive = st.ctrl[`QFX_CTRL_DERIVE];

	// default words
	// Unwritten words fall back to the port defaults or to zero.
	always_comb begin
		eff[0] = FIELD_WRITTEN_IN[`QFX_W_SWPRI] ? FIELDS_IN[`QFX_W_SWPRI] : cur[`QFX_SLOT_INIT_LO][15:0];
		eff[1] = FIELD_WRITTEN_IN[`QFX_W_OUTER] ? FIELDS_IN[`QFX_W_OUTER] : cur[`QFX_SLOT_INIT_LO][31:16];
		eff[2] = FIELD_WRITTEN_IN[`QFX_W_INNER] ? FIELDS_IN[`QFX_W_INNER] : cur[`QFX_SLOT_INIT_LO + 4'h1][15:0];
		eff[3] = FIELD_WRITTEN_IN[`QFX_W_SPARE] ? FIELDS_IN[`QFX_W_SPARE] :
			cur[`QFX_SLOT_INIT_HI + 4'h1][31:16];
		w_net = FIELD_WRITTEN_IN[`QFX_W_NET] ? FIELDS_IN[`QFX_W_NET] : 16'h0000;
	end

	// Builds the QoS group; the struct fixes the packing order.
	always_comb begin
		next_qos.switch_tag_priority = eff[0][`QFX_SWPRI_LSB +: `QFX_NIB];
		next_qos.outer_vlan_priority = qfx_lookup(cur[`QFX_SLOT_OUTER], cur[`QFX_SLOT_OUTER + 4'h1],
			eff[1][`QFX_VPRI_LSB +: `QFX_NIB]);
		next_qos.inner_vlan_priority = qfx_lookup(cur[`QFX_SLOT_INNER], cur[`QFX_SLOT_INNER + 4'h1],
			eff[2][`QFX_VPRI_LSB +: `QFX_NIB]);
		next_qos.network_priority = w_net[`QFX_NET_LSB +: `QFX_BYTE];
		next_qos.spare_qos_nibble = qfx_lookup(cur[`QFX_SLOT_SPARE], cur[`QFX_SLOT_SPARE + 4'h1],
			eff[3][`QFX_SPARE_LSB +: `QFX_NIB]);
	end

	// Seeds the flag vector. Program-owned bits pass untouched so that
	// microcode keeps full control of their meaning.
	always_comb begin
		next_flags = PARSER_FLAGS_IN;
		if (!PARSER_FLAGS_IN[`QFX_F_TAG_PRESENT]) begin
			next_flags[`QFX_F_TAG_FMT +: 2] = 2'b00;
		end
		// Hardware derivation can be switched off so microcode may reuse the bits.
		if (derive) begin
			next_flags[`QFX_F_DEST_NZ] = (DEST_PORT_TAG_ID_IN != 16'h0000);
			next_flags[`QFX_F_SRC_NZ] = (SRC_PORT_TAG_ID_IN != 16'h0000);
			next_flags[`QFX_F_MAPPED] = (DEST_IP_IN[127:32] == `QFX_MAPPED_PATTERN) ||
				(DEST_IP_IN[127:32] == 96'h0);
			next_flags[`QFX_F_HOP] = (HOP_LIMIT_IN <= `QFX_HOP_EXPIRED_MAX);
			next_flags[`QFX_F_MCAST] = DEST_MAC_IN[`QFX_MAC_MCAST_BIT];
		end
		next_flags[`QFX_F_SUM] = (HEADER_SUM_IN != `QFX_SUM_GOOD);
		next_flags[`QFX_F_SHORT] = SHORT_HEADER_IN;
		next_flags[`QFX_F_PARITY] = PARITY_FAULT_IN;
	end

	// ======================================================================
	// Next state: bus slave and output stage.
	always_comb begin
		logic       ok;
		logic [5:0] p;
		logic [3:0] s;
		logic [31:0] rv;
		logic [31:0] old;
		ok = 1'b0;
		p = 6'h00;
		s = 4'h0;
		rv = 32'h0000_0000;
		old = 32'h0000_0000;
		next_st = st;
		// Write channels are taken independently, in either order.
		if (AWVALID_IN && AWREADY_OUT) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = AWADDR_IN;
		end
		if (WVALID_IN && WREADY_OUT) begin
			next_st.w_got = 1'b1;
			next_st.wdata = WDATA_IN;
			next_st.wstrb = WSTRB_IN;
		end
		// Commit once both halves are held.
		if (st.aw_got && st.w_got) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `QFX_RESP_OKAY;
			qfx_decode(st.awaddr, ok, p, s);
			if (st.awaddr == `QFX_ADDR_CTRL) begin
				old = st.ctrl;
			end else if (ok) begin
				old = st.port_regs[p][s];
			end
			for (int b = 0; b < 4; b++) begin
				if (st.wstrb[b]) begin
					old[b*8 +: 8] = st.wdata[b*8 +: 8];
				end
			end
			if (st.awaddr == `QFX_ADDR_CTRL) begin
				next_st.ctrl = old;
			end else if (ok) begin
				next_st.port_regs[p][s] = old;
			end else if (st.awaddr > `QFX_ADDR_FLAGS_HI) begin
				next_st.bresp = `QFX_RESP_DECERR;
			end
		end
		if (st.bvalid && BREADY_IN) begin
			next_st.bvalid = 1'b0;
		end
		// Reads answer one cycle after the address is taken.
		if (ARVALID_IN && ARREADY_OUT) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `QFX_RESP_OKAY;
			qfx_decode(ARADDR_IN, ok, p, s);
			unique case (ARADDR_IN)
				`QFX_ADDR_CTRL: rv = st.ctrl;
				`QFX_ADDR_STATUS: rv = st.frame_count;
				`QFX_ADDR_LAST_QOS: rv = {8'h00, st.qos};
				`QFX_ADDR_FLAGS_LO: rv = st.flags[31:0];
				`QFX_ADDR_FLAGS_HI: rv = {24'h0, st.flags[39:32]};
				default: begin
					if (ok) begin
						rv = st.port_regs[p][s];
					end else begin
						next_st.rresp = `QFX_RESP_DECERR;
					end
				end
			endcase
			next_st.rdata = rv;
		end else if (st.rvalid && RREADY_IN) begin
			next_st.rvalid = 1'b0;
		end
		next_st.out_valid = FRAME_VALID_IN;
		if (FRAME_VALID_IN) begin
			next_st.qos = next_qos;
			next_st.flags = next_flags;
			next_st.frame_count = st.frame_count + 32'h0000_0001;
		end
	end

	// Registers the whole state; the enable freezes everything.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			st <= '0;
			st.ctrl <= `QFX_CTRL_RESET;
		end else if (CE_IN) begin
			st <= next_st;
		end
	end

	// ======================================================================
	// Outputs.
	// Ready only while enabled, so a master never sees an AW, W or AR handshake that the frozen state ignores; BVALID and RVALID are not gated.
	assign AWREADY_OUT = CE_IN && !st.aw_got && !st.bvalid;
	assign WREADY_OUT = CE_IN && !st.w_got && !st.bvalid;
	assign BVALID_OUT = st.bvalid;
	assign BRESP_OUT = st.bresp;
	assign ARREADY_OUT = CE_IN && !st.rvalid;
	assign RVALID_OUT = st.rvalid;
	assign RDATA_OUT = st.rdata;
	assign RRESP_OUT = st.rresp;
	assign FRAME_VALID_OUT = st.out_valid;
	assign QOS_OUT = st.qos;
	assign SWITCH_TAG_PRIORITY_OUT = st.qos.switch_tag_priority;
	assign OUTER_VLAN_PRIORITY_OUT = st.qos.outer_vlan_priority;
	assign INNER_VLAN_PRIORITY_OUT = st.qos.inner_vlan_priority;
	assign NETWORK_PRIORITY_OUT = st.qos.network_priority;
	assign DSCP_OUT = st.qos.network_priority[`QFX_DSCP_LSB +: `QFX_DSCP_W];
	assign SPARE_QOS_NIBBLE_OUT = st.qos.spare_qos_nibble;
	assign ACTION_FLAGS_OUT = st.flags;

	// ======================================================================
	// Assertions.
	a_switch_prio_word: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN && FIELD_WRITTEN_IN[`QFX_W_SWPRI] |=>
		SWITCH_TAG_PRIORITY_OUT == $past(FIELDS_IN[`QFX_W_SWPRI][`QFX_SWPRI_LSB +: `QFX_NIB]))
		else $error("switch priority not taken from word 0");
	a_net_prio_byte: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN |=> NETWORK_PRIORITY_OUT ==
		($past(FIELD_WRITTEN_IN[`QFX_W_NET]) ? $past(FIELDS_IN[`QFX_W_NET][7:0]) : 8'h00))
		else $error("network priority wrong");
	a_dscp_view: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN |=> DSCP_OUT == ($past(FIELD_WRITTEN_IN[`QFX_W_NET]) ?
		$past(FIELDS_IN[`QFX_W_NET][`QFX_DSCP_LSB +: `QFX_DSCP_W]) : 6'h00))
		else $error("dscp not taken from the network priority");
	a_qos_order: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN && FIELD_WRITTEN_IN[`QFX_W_SWPRI] && FIELD_WRITTEN_IN[`QFX_W_NET] |=>
		QOS_OUT[`QFX_QOS_SWPRI_LSB +: `QFX_NIB] == $past(FIELDS_IN[`QFX_W_SWPRI][`QFX_SWPRI_LSB +: `QFX_NIB]) &&
		QOS_OUT[`QFX_QOS_NET_LSB +: `QFX_BYTE] == $past(FIELDS_IN[`QFX_W_NET][`QFX_NET_LSB +: `QFX_BYTE]))
		else $error("qos packing order broken");
	a_valid_follows: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN |=> FRAME_VALID_OUT == $past(FRAME_VALID_IN))
		else $error("frame valid not one cycle later");
	a_sum_error: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN |=> ACTION_FLAGS_OUT[`QFX_F_SUM] == ($past(HEADER_SUM_IN) != `QFX_SUM_GOOD))
		else $error("checksum flag wrong");
	a_short_header: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN |=> ACTION_FLAGS_OUT[`QFX_F_SHORT] == $past(SHORT_HEADER_IN))
		else $error("short header flag wrong");
	a_hop_expired: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN && derive |=> ACTION_FLAGS_OUT[`QFX_F_HOP] == ($past(HOP_LIMIT_IN) < 8'h02))
		else $error("hop limit flag wrong");
	a_mcast_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		CE_IN && FRAME_VALID_IN && derive |=>
		ACTION_FLAGS_OUT[`QFX_F_MCAST] == $past(DEST_MAC_IN[`QFX_MAC_MCAST_BIT]))
		else $error("multicast flag wrong");
	a_tag_format: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		FRAME_VALID_OUT && !ACTION_FLAGS_OUT[`QFX_F_TAG_PRESENT] |-> ACTION_FLAGS_OUT[3:2] == 2'b00)
		else $error("tag format set without tag");
	// Enable low must hold every register, bus state included.
	a_ce_freeze: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!CE_IN |=> $stable(st))
		else $error("state moved while enable low");

endmodule

//--- verif/qfx_downstream_model.sv
// ==========================================================================
// Next pipeline stage: takes the group and the flags at each frame pulse.
module qfx_downstream_model (
	// Clock.
	input  wire logic        clk_in,
	// Stage outputs seen.
	input  wire logic        valid_in,
	input  wire logic [23:0] qos_in,
	input  wire logic [23:0] slices_in,
	input  wire logic [5:0]  dscp_in,
	input  wire logic [39:0] flags_in,
	// What the next stage took.
	output logic             took_out,
	output logic [63:0]      frame_out,
	output logic [29:0]      parts_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// grouped capture
	// There is no back-pressure, so a frame must be taken in its one cycle.
	always @(posedge clk_in) begin
		took_out  <= valid_in;
		frame_out <= {qos_in, flags_in};
		parts_out <= {slices_in, dscp_in};
	end
endmodule

//--- verif/qfx_extract_tb.sv
`include "qfx_params.svh"

// ==========================================================================
// Self-checking bench for the extract stage.
module qfx_extract_tb
	import qfx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] INIT_A = 32'hA5C3_0B00;
	localparam logic [31:0] INIT_B = 32'h0700_0000;
	logic              clk, rst, ce, fv, shrt, par, fvo, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy, took;
	logic [5:0]        src, dscp;
	logic [43:0][15:0] fld;
	logic [43:0]       wm;
	logic [39:0]       pf, flg;
	logic [15:0]       sum, dt, st;
	logic [127:0]      dip;
	logic [7:0]        hop, np;
	logic [47:0]       mac;
	logic [23:0]       qos;
	logic [3:0]        swp, ovp, ivp, spn, wstrb;
	logic [11:0]       awa, ara;
	logic [31:0]       wd, rd, seed;
	logic [1:0]        bresp, rresp;
	logic [63:0]       got, fe;
	logic [29:0]       parts;
	logic [33:0]       be;
	logic [63:0]       fq[$];
	logic [33:0]       bq[$], rq[$];
	int                fails, n_tests, cyc;

	// Design and next stage.
	qfx_extract #(.NUM_PORTS(4)) u_qfx_extract (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
		.FRAME_VALID_IN(fv), .SRC_PORT_IN(src), .FIELDS_IN(fld), .FIELD_WRITTEN_IN(wm),
		.PARSER_FLAGS_IN(pf), .HEADER_SUM_IN(sum), .SHORT_HEADER_IN(shrt), .PARITY_FAULT_IN(par),
		.DEST_PORT_TAG_ID_IN(dt), .SRC_PORT_TAG_ID_IN(st), .DEST_IP_IN(dip), .HOP_LIMIT_IN(hop),
		.DEST_MAC_IN(mac), .FRAME_VALID_OUT(fvo), .QOS_OUT(qos), .SWITCH_TAG_PRIORITY_OUT(swp),
		.OUTER_VLAN_PRIORITY_OUT(ovp), .INNER_VLAN_PRIORITY_OUT(ivp), .NETWORK_PRIORITY_OUT(np),
		.DSCP_OUT(dscp), .SPARE_QOS_NIBBLE_OUT(spn), .ACTION_FLAGS_OUT(flg), .AWADDR_IN(awa),
		.AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(wstrb), .WVALID_IN(wv),
		.WREADY_OUT(wrdy), .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(brdy), .ARADDR_IN(ara),
		.ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rresp), .RVALID_OUT(rv),
		.RREADY_IN(rrdy));
	qfx_downstream_model u_qfx_downstream_model (.clk_in(clk), .valid_in(fvo), .qos_in(qos),
		.slices_in({swp, ovp, ivp, np, spn}), .dscp_in(dscp), .flags_in(flg), .took_out(took),
		.frame_out(got), .parts_out(parts));

	// ======================================================================
	// Clock, timeout and helpers.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// A hang counts as a mismatch and ends the run.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			close_out();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic close_out();
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic cmp_frame(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// ======================================================================
	// Bus master; the handshake is judged just before the taking edge.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input qfx_resp_t r);
		logic pa, pw, ta, tw;
		bq.push_back({r, 32'h0});
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (pa | pw) begin
			@(negedge clk);
			ta = pa & (awr === 1'b1);
			tw = pw & (wrdy === 1'b1);
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			pa = pa & ~ta;
			pw = pw & ~tw;
		end
		do begin
			if (bv !== 1'b1) @(posedge clk);
			@(negedge clk);
			ta = (bv === 1'b1);
		end while (!ta);
		@(posedge clk);
		brdy <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
		logic t;
		rq.push_back(e);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(negedge clk);
			t = (arr === 1'b1);
			@(posedge clk);
		end while (!t);
		arv <= 1'b0;
		do begin
			@(negedge clk);
			t = (rv === 1'b1);
			@(posedge clk);
		end while (!t);
		rrdy <= 1'b0;
	endtask

	// ======================================================================
	// Back-to-back frames with random fields; the note is the expectation.
	task automatic frames(input int n, input logic derive, input logic holes);
		logic [43:0][15:0] f;
		logic [43:0]       m;
		logic [15:0]       w0, w1, w2, w11, w16, sm, d, s2;
		logic [95:0]       up;
		logic [39:0]       p, x;
		logic [31:0]       s;
		logic [7:0]        h;
		logic [47:0]       mc;
		logic [5:0]        sr;
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 44; i++) f[i] = 16'(rnd());
			s = rnd();
			m = holes ? ~(44'(rnd()) & 44'h000_0001_0807) : {44{1'b1}};
			w0 = m[0] ? f[0] : INIT_A[15:0];
			w1 = m[1] ? f[1] : INIT_A[31:16];
			w2 = m[2] ? f[2] : 16'h0000;
			w11 = m[11] ? f[11] : INIT_B[31:16];
			w16 = m[16] ? f[16] : 16'h0000;
			p = 40'({rnd(), rnd()});
			d = s[0] ? 16'h0000 : 16'(rnd());
			s2 = s[1] ? 16'h0000 : 16'(rnd());
			h = s[4] ? {6'h00, s[3:2]} : 8'(rnd());
			up = (s[6:5] == 2'h0) ? 96'h0 : (s[6:5] == 2'h1) ? 96'hFFFF : (s[6:5] == 2'h2) ? 96'h1_0000_FFFF
				: {rnd(), rnd(), rnd()};
			sm = s[7] ? 16'hFFFF : 16'(rnd());
			mc = 48'({rnd(), rnd()});
			sr = 6'(rnd());
			if (sr > 6'h00 && sr < 6'h04) sr = 6'h00;
			x = p;
			if (!p[1]) x[3:2] = 2'h0;
			if (derive) begin
				x[10] = (d != 16'h0000);
				x[11] = (s2 != 16'h0000);
				x[12] = (up == 96'h0) || (up == 96'hFFFF);
				x[13] = (h <= 8'h01);
				x[17] = mc[40];
			end
			x[37] = (sm != 16'hFFFF);
			x[38] = s[8];
			x[39] = s[9];
			fq.push_back({~w0[11:8] ^ 4'hF, ~w1[15:12], w2[15:12], w16[7:0], ~w11[11:8], x});
			@(posedge clk);
			fv <= 1'b1;
			fld <= f;
			wm <= m;
			pf <= p;
			dt <= d;
			st <= s2;
			hop <= h;
			dip <= {up, rnd()};
			sum <= sm;
			shrt <= s[8];
			par <= s[9];
			mac <= mc;
			src <= sr;
		end
		@(posedge clk);
		fv <= 1'b0;
	endtask

	// ======================================================================
	// Result watchers take the oldest note for each result seen.
	always @(negedge clk) begin
		if (took === 1'b1) begin
			fe = fq.pop_front();
			cmp_frame(got, fe);
			cmp_frame({34'h0, parts}, {34'h0, fe[63:40], fe[51:46]});
		end
		if (bv === 1'b1 && brdy === 1'b1) begin
			be = bq.pop_front();
			cmp_bus({bresp, 32'h0}, be);
		end
		if (rv === 1'b1 && rrdy === 1'b1) begin
			be = rq.pop_front();
			cmp_bus({rresp, rd}, be);
		end
	end

	// ======================================================================
	// Main sequence: tables, frames with derive on and off, frame count.
	initial begin
		seed = 32'h0000_0050;
		{rst, fv, shrt, par, awv, wv, brdy, arv, rrdy} = 9'h100;
		ce = 1'b1;
		{src, fld, wm, pf, sum, dt, st, dip, hop, mac} = '0;
		{awa, ara, wd} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axi_rd(`QFX_ADDR_CTRL, {`QFX_RESP_OKAY, `QFX_CTRL_RESET});
		axi_rd(12'h0F0, {`QFX_RESP_DECERR, 32'h0});
		axi_wr(12'h0F0, 32'h1234_5678, `QFX_RESP_DECERR);
		for (int i = 0; i < 8; i++) begin
			axi_wr(`QFX_PORT_BASE + 12'(4 * (i < 6 ? i : (i == 6 ? 6 : 9))),
				(i == 6) ? INIT_A : (i == 7) ? INIT_B : (i == 2) ? 32'h7654_3210 : (i == 3) ? 32'hFEDC_BA98
				: i[0] ? 32'h0123_4567 : 32'h89AB_CDEF, `QFX_RESP_OKAY);
		end
		axi_rd(`QFX_PORT_BASE, {`QFX_RESP_OKAY, 32'h89AB_CDEF});
		frames(30, 1'b1, 1'b0);
		frames(15, 1'b1, 1'b1);
		axi_wr(`QFX_ADDR_CTRL, 32'h0, `QFX_RESP_OKAY);
		frames(15, 1'b0, 1'b1);
		repeat (3) @(posedge clk);
		// A frame offered while the enable is low must be neither taken nor counted.
		ce <= 1'b0;
		fv <= 1'b1;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		fv <= 1'b0;
		axi_rd(`QFX_ADDR_STATUS, {`QFX_RESP_OKAY, 32'd60});
		repeat (3) @(posedge clk);
		// Every note must have met its result; a silent output would leave notes behind.
		cmp_bus(34'(fq.size() + bq.size() + rq.size()), 34'h0);
		close_out();
	end
endmodule
